// ### bfc_regs.sv
`timescale 1ns/1ns
`include "bfc_defines.svh"
module bfc_regs
#(
  parameter int OFS_W = 10
)
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Wide port register access
  input wire logic wide_port_chip_select_n,
  input wire logic wide_port_select_high,
  input wire logic wide_port_select_low,
  input wire logic wide_port_wr,
  input wire logic wide_port_rd,
  input wire logic [15:0] wide_port_wdata,
  output logic [15:0] wide_port_rdata,
  // Internal flags and narrow-port events
  input wire bfc_pkg::bfc_flags_t flags_in,
  input wire logic half_word_written,
  input wire logic half_word_merged,
  input wire logic [7:0] half_word_data,
  input wire logic write_parity_err,
  input wire logic read_parity_err,
  input wire logic narrow_byte_done,
  input wire logic dma_clk_pin,
  // External flag pins
  output logic flag_pin_a,
  output logic flag_pin_b,
  output logic flag_pin_c,
  output logic flag_pin_d,
  // Reset pulses to the datapath
  output logic inbound_ptr_clr,
  output logic outbound_ptr_clr,
  output logic dma_req_clr,
  // Configuration seen by the datapath
  output bfc_pkg::bfc_gctl_t gctl_out,
  output logic [15:0] parity_ctl,
  output logic [OFS_W-1:0] ob_ae_ofs,
  output logic [OFS_W-1:0] ob_af_ofs,
  output logic [OFS_W-1:0] ib_ae_ofs,
  output logic [OFS_W-1:0] ib_af_ofs,
  output logic dma_dir_read,
  output logic half_word_valid,
  output logic dma_tick,
  output logic ask_pol_eff,
  output logic grant_pol_eff,
  output logic [2:0] ask_grant_clocks,
  output logic [1:0] strobe_clocks,
  output logic byte_to_self
);

  // Only the nine- and ten-bit offset variants exist
  generate
    if (OFS_W < 9 || OFS_W > 10)
    begin : g_bad_ofs_w
      $error("OFS_W must be 9 or 10");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic sel;
  logic cmd_wr;
  logic cfg_wr;
  logic st_rd;
  logic cfg_rd;
  logic [3:0] opc;
  logic [2:0] opd;
  logic soft_rst;
  logic clr_inb;
  logic clr_outb;
  logic clr_dma;
  logic clr_all;
  logic [3:0] rst_sel;

  // Both selects high is the command/status slot, high-only the data slot
  assign sel = !wide_port_chip_select_n && wide_port_select_high;
  assign cmd_wr = sel && wide_port_select_low && wide_port_wr;
  assign cfg_wr = sel && !wide_port_select_low && wide_port_wr;
  assign st_rd = sel && wide_port_select_low && wide_port_rd;
  assign cfg_rd = sel && !wide_port_select_low && wide_port_rd;
  assign opc = wide_port_wdata[`BFC_OPC_HI:`BFC_OPC_LO];
  assign opd = wide_port_wdata[`BFC_OPD_HI:`BFC_OPD_LO];
  assign soft_rst = cmd_wr && opc == `BFC_OP_RESET;

  // Decode of the reset operand, shared by several registers
  function automatic logic [3:0] rst_decode(input logic [2:0] o);
    logic [3:0] r;
    r = 4'h0;
    case (o)
      `BFC_RST_INB: r = 4'h1;
      `BFC_RST_OUTB: r = 4'h2;
      `BFC_RST_BOTH: r = 4'h3;
      `BFC_RST_DMA: r = 4'h4;
      `BFC_RST_ALL: r = 4'hf;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // Decoded once into a vector, since a call result cannot be bit-selected
  assign rst_sel = rst_decode(opd);
  assign clr_inb = soft_rst && rst_sel[0];
  assign clr_outb = soft_rst && rst_sel[1];
  assign clr_dma = soft_rst && rst_sel[2];
  assign clr_all = soft_rst && rst_sel[3];

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [2:0] cfg_idx_r;
  logic [OFS_W-1:0] ofs_r [4];
  logic [15:0] flags_asg_r;
  bfc_pkg::bfc_gctl_t gctl_r;
  logic [15:0] par_r;

  // Selected configuration register index
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cfg_idx_r <= 3'h0;
    else if (clk_en && cmd_wr && opc == `BFC_OP_SELCFG)
      cfg_idx_r <= opd;
  end

  // Offset registers; only OFS_W bits are stored, rest read zero
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_ofs
      always_ff @(posedge ref_clk)
      begin
        if (rst)
          ofs_r[gi] <= OFS_W'(`BFC_OFS_RST);
        else if (clk_en && clr_all)
          ofs_r[gi] <= OFS_W'(`BFC_OFS_RST);
        else if (clk_en && cfg_wr && cfg_idx_r == 3'(gi))
          ofs_r[gi] <= wide_port_wdata[OFS_W-1:0];
      end
    end
  endgenerate

  // Flag assignment, general control and parity control
  always_ff @(posedge ref_clk)
  begin
    if (rst || (clk_en && clr_all))
    begin
      flags_asg_r <= `BFC_FLAGS_RST;
      gctl_r <= `BFC_GCTL_RST;
      par_r <= `BFC_PAR_RST;
    end
    else if (clk_en && cfg_wr)
    begin
      if (cfg_idx_r == `BFC_CFG_FLAGS)
        flags_asg_r <= wide_port_wdata;
      if (cfg_idx_r == `BFC_CFG_GCTL)
        gctl_r <= wide_port_wdata;
      if (cfg_idx_r == `BFC_CFG_PAR)
        par_r <= wide_port_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Hardware-reset-only state, except half-word valid, which inbound soft resets also clear
  // ----------------------------------------------------------------
  logic layout_r;
  logic dma_dir_r;
  logic wpe_r;
  logic rpe_r;
  logic valid_r;

  // Layout and DMA direction survive every software reset
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      layout_r <= 1'b0;
      dma_dir_r <= 1'b0;
    end
    else if (clk_en && cmd_wr)
    begin
      if (opc == `BFC_OP_LAYOUT)
        layout_r <= opd[0];
      if (opc == `BFC_OP_DMADIR && gctl_r.periph_mode)
        dma_dir_r <= opd[0];
    end
  end

  // Parity errors: a new error wins over a clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wpe_r <= 1'b0;
      rpe_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (write_parity_err)
        wpe_r <= 1'b1;
      else if (cmd_wr && opc == `BFC_OP_CLR_WPE)
        wpe_r <= 1'b0;
      if (read_parity_err)
        rpe_r <= 1'b1;
      else if (cmd_wr && opc == `BFC_OP_CLR_RPE)
        rpe_r <= 1'b0;
    end
  end

  // Half-word valid; a fresh first half beats a concurrent clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      valid_r <= 1'b0;
    else if (clk_en)
    begin
      if (half_word_written)
        valid_r <= 1'b1;
      else if (half_word_merged || clr_inb)
        valid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset pulses to the datapath
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      inbound_ptr_clr <= 1'b1;
      outbound_ptr_clr <= 1'b1;
      dma_req_clr <= 1'b1;
    end
    else if (clk_en)
    begin
      inbound_ptr_clr <= clr_inb;
      outbound_ptr_clr <= clr_outb;
      dma_req_clr <= clr_dma;
    end
  end

  // ----------------------------------------------------------------
  // Status word and read data
  // ----------------------------------------------------------------
  logic [15:0] status;
  logic [15:0] cfg_rdata;

  // Upper byte is common; low byte depends on layout
  always_comb
  begin
    status = 16'h0000;
    status[15:8] = {flags_in.ib_aempty, flags_in.ib_empty,
                    flags_in.ob_afull, flags_in.ob_full,
                    layout_r, rpe_r, wpe_r, valid_r};
    if (!layout_r)
      status[7:0] = half_word_data;
    else
    begin
      status[7:4] = {flags_in.ib_afull, flags_in.ib_full,
                     flags_in.ob_aempty, flags_in.ob_empty};
      status[`BFC_ST_DMADIR] = dma_dir_r;
    end
  end

  // Reserved register 6 and unused offset bits read as zero
  always_comb
  begin
    cfg_rdata = 16'h0000;
    case (cfg_idx_r)
      `BFC_CFG_OB_AE: cfg_rdata[OFS_W-1:0] = ofs_r[0];
      `BFC_CFG_OB_AF: cfg_rdata[OFS_W-1:0] = ofs_r[1];
      `BFC_CFG_IB_AE: cfg_rdata[OFS_W-1:0] = ofs_r[2];
      `BFC_CFG_IB_AF: cfg_rdata[OFS_W-1:0] = ofs_r[3];
      `BFC_CFG_FLAGS: cfg_rdata = flags_asg_r;
      `BFC_CFG_GCTL: cfg_rdata = gctl_r;
      `BFC_CFG_PAR: cfg_rdata = par_r;
      default: cfg_rdata = 16'h0000;
    endcase
  end

  // Read data is captured on the read cycle and held until the next
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wide_port_rdata <= 16'h0000;
    else if (clk_en && st_rd)
      wide_port_rdata <= status;
    else if (clk_en && cfg_rd)
      wide_port_rdata <= cfg_rdata;
  end

  // ----------------------------------------------------------------
  // External flag pins
  // ----------------------------------------------------------------
  // The top code bit is ignored so codes 8-15 alias codes 0-7
  function automatic logic pick_flag(input logic [3:0] code,
                                     input bfc_pkg::bfc_flags_t f);
    return f[code[2:0]];
  endfunction

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      flag_pin_a <= 1'b0;
      flag_pin_b <= 1'b0;
      flag_pin_c <= 1'b0;
      flag_pin_d <= 1'b0;
    end
    else if (clk_en)
    begin
      if (par_r[`BFC_PAR_TO_PIN_A])
        flag_pin_a <= wpe_r || rpe_r;
      else
        flag_pin_a <= pick_flag(flags_asg_r[3:0], flags_in);
      flag_pin_b <= pick_flag(flags_asg_r[7:4], flags_in);
      flag_pin_c <= pick_flag(flags_asg_r[11:8], flags_in);
      flag_pin_d <= pick_flag(flags_asg_r[15:12], flags_in);
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // The derived DMA outputs are forced quiet outside peripheral mode; gctl_out
  // still carries the raw DMA fields while the port is a processor port
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      gctl_out <= `BFC_GCTL_RST;
      ask_pol_eff <= 1'b0;
      grant_pol_eff <= 1'b0;
      ask_grant_clocks <= `BFC_ASK_GRANT_BASE;
      strobe_clocks <= 2'h1;
    end
    else if (clk_en)
    begin
      gctl_out <= gctl_r;
      ask_pol_eff <= gctl_r.periph_mode && gctl_r.ask_pol;
      grant_pol_eff <= gctl_r.periph_mode && gctl_r.grant_pol;
      if (gctl_r.periph_mode)
      begin
        ask_grant_clocks <= `BFC_ASK_GRANT_BASE
                            + {1'b0, gctl_r.ask_grant_code};
        strobe_clocks <= gctl_r.strobe_two ? 2'h2 : 2'h1;
      end
      else
      begin
        ask_grant_clocks <= `BFC_ASK_GRANT_BASE;
        strobe_clocks <= 2'h1;
      end
    end
  end

  // Plain copies of stored state
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      parity_ctl <= `BFC_PAR_RST;
      ob_ae_ofs <= '0;
      ob_af_ofs <= '0;
      ib_ae_ofs <= '0;
      ib_af_ofs <= '0;
      dma_dir_read <= 1'b0;
      half_word_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      parity_ctl <= par_r;
      ob_ae_ofs <= ofs_r[0];
      ob_af_ofs <= ofs_r[1];
      ib_ae_ofs <= ofs_r[2];
      ib_af_ofs <= ofs_r[3];
      dma_dir_read <= dma_dir_r;
      half_word_valid <= valid_r;
    end
  end

  // ----------------------------------------------------------------
  // DMA internal clock
  // ----------------------------------------------------------------
  logic pin_prev_r;
  logic half_ph_r;
  logic pin_rise;

  assign pin_rise = dma_clk_pin && !pin_prev_r;

  // Tick on each pin rise, or every second rise when halved; phase is
  // part of the request logic and restarts with it
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pin_prev_r <= 1'b0;
      half_ph_r <= 1'b0;
      dma_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_prev_r <= dma_clk_pin;
      if (clr_dma)
      begin
        half_ph_r <= 1'b0;
        dma_tick <= 1'b0;
      end
      else
      begin
        if (pin_rise)
          half_ph_r <= !half_ph_r;
        dma_tick <= gctl_r.periph_mode && pin_rise
                    && (!gctl_r.clk_half || half_ph_r);
      end
    end
  end

  // ----------------------------------------------------------------
  // Master width expansion byte steering
  // ----------------------------------------------------------------
  logic [1:0] byte_cnt_r;

  // Bytes 0-1 of each group of four go to the slave, 2-3 stay here
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      byte_cnt_r <= 2'h0;
      byte_to_self <= 1'b0;
    end
    else if (clk_en)
    begin
      if (clr_inb || clr_outb)
        byte_cnt_r <= 2'h0;
      else if (narrow_byte_done)
        byte_cnt_r <= byte_cnt_r + 2'h1;
      if (gctl_r.width_mode == bfc_pkg::BFC_MASTER)
        byte_to_self <= byte_cnt_r[1];
      else
        byte_to_self <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_reset_all;
    clk_en && soft_rst && opd == `BFC_RST_ALL;
  endsequence

  property p_ofs_clear;
    @(posedge ref_clk) disable iff (rst)
    s_reset_all |=> ##1 (ob_ae_ofs == '0 && ib_af_ofs == '0);
  endproperty
  a_ofs_clear: assert property (p_ofs_clear)
    else $error("offsets not zero after reset-all");

  property p_flags_default;
    @(posedge ref_clk) disable iff (rst)
    s_reset_all |=> (flags_asg_r == `BFC_FLAGS_RST);
  endproperty
  a_flags_default: assert property (p_flags_default)
    else $error("flag assignment not default after reset-all");

  property p_layout_kept;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && soft_rst) |=> $stable(layout_r) && $stable(dma_dir_r);
  endproperty
  a_layout_kept: assert property (p_layout_kept)
    else $error("software reset changed layout or direction");

  property p_inb_clr;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && soft_rst && (opd == `BFC_RST_OUTB || opd == `BFC_RST_DMA))
      |=> !inbound_ptr_clr;
  endproperty
  a_inb_clr: assert property (p_inb_clr)
    else $error("inbound pointers cleared by wrong operand");

  property p_outb_clr;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && soft_rst && opd == `BFC_RST_BOTH) |=> outbound_ptr_clr;
  endproperty
  a_outb_clr: assert property (p_outb_clr)
    else $error("outbound pointers not cleared");

  property p_status_layout0;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && st_rd && !layout_r)
      |=> (wide_port_rdata[`BFC_ST_LAYOUT] == 1'b0
           && wide_port_rdata[7:0] == $past(half_word_data));
  endproperty
  a_status_layout0: assert property (p_status_layout0)
    else $error("layout zero status wrong");

  property p_status_layout1;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && st_rd && layout_r)
      |=> (wide_port_rdata[`BFC_ST_LAYOUT] == 1'b1
           && wide_port_rdata[2:0] == 3'h0);
  endproperty
  a_status_layout1: assert property (p_status_layout1)
    else $error("layout one status wrong");

  property p_delay;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && gctl_r.periph_mode) |=>
      (ask_grant_clocks >= 3'h2 && ask_grant_clocks <= 3'h5);
  endproperty
  a_delay: assert property (p_delay)
    else $error("ask-to-grant delay out of range");

  property p_proc_quiet;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && !gctl_r.periph_mode) |=> !ask_pol_eff && !dma_tick;
  endproperty
  a_proc_quiet: assert property (p_proc_quiet)
    else $error("DMA active in processor mode");

endmodule

// ### bfc_defines.svh
`ifndef BFC_DEFINES_SVH
`define BFC_DEFINES_SVH
// How it works
// - Hardware reset or reset-all zeroes all four flag offset registers.
// - Flag assignment defaults to 6420h on hardware reset or reset-all.
// - Only hardware reset sets layout zero, inbound DMA, clears parity errors.
// - Inbound pointers clear on hardware reset and operands 001, 011, 111.
// - Outbound pointers clear on hardware reset and operands 010, 011, 111.
// - Half-word valid clears on hardware reset and operands 001, 011, 111.
// - Operand 100, reset-all and hardware reset clear the DMA request logic.
// - Chip select low with both selects high reads the chosen status layout.
// - Upper status byte: valid, parity errors, layout, four flags.
// - Layout zero: low byte is pending half-word data, bit 11 zero.
// - Layout one: bit 3 DMA direction, bits 4-7 flags, bit 11 one.
// - Offsets are ten bits; small variant uses nine, host writes bit 9 zero.
// - Four 4-bit codes each pick the internal flag for one pin.
// - Codes 0-7 map the eight flags; top bit set repeats the mapping.
// - Control bit 0 selects separate strobes or data strobe with direction.
// - Control bit 1 swaps the order of the two narrow-port halves.
// - Control bits 2 and 3 protect reread or rewrite data via flags.
// - Bits 4, 5 set ask and grant polarity; bits 4-9 need peripheral mode.
// - DMA runs on an internal clock: external clock pin or half of it.
// - Bit 8 selects one or two internal clocks of strobe assertion.
// - Bits 6, 7 set ask-to-grant delay of 2 to 5 internal clocks.
// - Bit 10 selects processor mode or peripheral mode with DMA active.
// - Bits 11, 12 select stand-alone, master or slave width expansion.
// - Master passes two bytes to the slave, takes two, and alternates.
// - Parity control register clears on hardware reset and reset-all.

// Command opcodes and operands
`define BFC_OP_RESET 4'h0
`define BFC_OP_SELCFG 4'h1
`define BFC_OP_DMADIR 4'h6
`define BFC_OP_LAYOUT 4'h7
`define BFC_OP_CLR_WPE 4'ha
`define BFC_OP_CLR_RPE 4'hb
`define BFC_RST_INB 3'h1
`define BFC_RST_OUTB 3'h2
`define BFC_RST_BOTH 3'h3
`define BFC_RST_DMA 3'h4
`define BFC_RST_ALL 3'h7
// Command field positions
`define BFC_OPC_HI 11
`define BFC_OPC_LO 8
`define BFC_OPD_HI 2
`define BFC_OPD_LO 0
// Configuration register indices
`define BFC_CFG_OB_AE 3'h0
`define BFC_CFG_OB_AF 3'h1
`define BFC_CFG_IB_AE 3'h2
`define BFC_CFG_IB_AF 3'h3
`define BFC_CFG_FLAGS 3'h4
`define BFC_CFG_GCTL 3'h5
`define BFC_CFG_PAR 3'h7
// Reset values
`define BFC_OFS_RST 16'h0000
`define BFC_FLAGS_RST 16'h6420
`define BFC_GCTL_RST 16'h0000
`define BFC_PAR_RST 16'h0000
// Status bit positions
`define BFC_ST_DMADIR 3
`define BFC_ST_LAYOUT 11
// Parity control bit that routes parity error to pin a
`define BFC_PAR_TO_PIN_A 11
// Ask-to-grant delay in internal clocks for code zero
`define BFC_ASK_GRANT_BASE 3'h2
`endif

// ### bfc_pkg.sv
package bfc_pkg;
  // Width expansion modes
  typedef enum logic [1:0] {
    BFC_STANDALONE = 2'h0,
    BFC_MASTER = 2'h1,
    BFC_SLAVE = 2'h2,
    BFC_WX_RSVD = 2'h3
  } bfc_width_t;

  // General control register fields, msb first
  typedef struct packed {
    logic [2:0] rsvd;
    bfc_width_t width_mode;
    logic periph_mode;
    logic clk_half;
    logic strobe_two;
    logic [1:0] ask_grant_code;
    logic grant_pol;
    logic ask_pol;
    logic protect_rewrite;
    logic protect_reread;
    logic swap_halves;
    logic strobe_style;
  } bfc_gctl_t;

  // Eight internal flags, bit index equals assignment code
  typedef struct packed {
    logic ib_afull;
    logic ib_full;
    logic ib_aempty;
    logic ib_empty;
    logic ob_afull;
    logic ob_full;
    logic ob_aempty;
    logic ob_empty;
  } bfc_flags_t;
endpackage

// ### bfc_host.sv
`timescale 1ns/1ns
// --------------------------------------------------
// Host processor model on the wide port
// --------------------------------------------------
module bfc_host
(
  // Clock
  input wire logic ref_clk,
  // Wide port access
  output logic cs_n,
  output logic sel_hi,
  output logic sel_lo,
  output logic wr,
  output logic rd,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  // Idle bus: deselected, both strobes low
  initial
  begin
    cs_n = 1'b1;
    sel_hi = 1'b1;
    sel_lo = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 16'h0000;
  end

  // One write: lo high is the command slot, low the config slot
  task automatic put(input logic lo, input logic [15:0] d);
    @(negedge ref_clk);
    cs_n = 1'b0;
    sel_lo = lo;
    wdata = d;
    wr = 1'b1;
    @(negedge ref_clk);
    wr = 1'b0;
    cs_n = 1'b1;
    wdata = ~d; // Stale data must never look like a valid write
  endtask

  // One read; data taken a cycle and a half after the taking edge
  task automatic get(input logic lo, output logic [15:0] d);
    @(negedge ref_clk);
    cs_n = 1'b0;
    sel_lo = lo;
    rd = 1'b1;
    @(negedge ref_clk);
    rd = 1'b0;
    cs_n = 1'b1;
    @(negedge ref_clk);
    d = rdata;
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ns
`define CHK(n, e, a) \
  begin \
    compares++; \
    if ((e) !== (a)) \
    begin \
      bad_count++; \
      $display("MISMATCH %s exp %h got %h", n, e, a); \
    end \
  end
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic cs_n, sel_hi, sel_lo, wr, rd;
  logic [15:0] wdata, rdata, d;
  bfc_pkg::bfc_flags_t fl = 8'h96;
  logic hw_wr = 1'b0, hw_mg = 1'b0, wpe = 1'b0, rpe = 1'b0;
  logic nb = 1'b0, dclk = 1'b0;
  logic [7:0] hwd = 8'ha5;
  logic fa, fb, fc, fd, ic, oc, dc, hv, tick, app, gpp, bts, ddr;
  logic [15:0] pc;
  logic [9:0] oae, oaf, iae, iaf;
  logic [2:0] agc;
  logic [1:0] stc;
  bfc_pkg::bfc_gctl_t go;
  logic [2:0] seen;
  logic seen_clr = 1'b0, ep_w = 1'b0, ep_r = 1'b0, hv_e = 1'b0, ib;
  int bad_count = 0, compares = 0, ticks = 0, t0;

  bfc_host i_bfc_host (.ref_clk(ref_clk), .cs_n(cs_n), .sel_hi(sel_hi),
    .sel_lo(sel_lo), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata));

  bfc_regs i_bfc_regs (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .wide_port_chip_select_n(cs_n), .wide_port_select_high(sel_hi),
    .wide_port_select_low(sel_lo), .wide_port_wr(wr), .wide_port_rd(rd),
    .wide_port_wdata(wdata), .wide_port_rdata(rdata), .flags_in(fl),
    .half_word_written(hw_wr), .half_word_merged(hw_mg),
    .half_word_data(hwd), .write_parity_err(wpe), .read_parity_err(rpe),
    .narrow_byte_done(nb), .dma_clk_pin(dclk), .flag_pin_a(fa),
    .flag_pin_b(fb), .flag_pin_c(fc), .flag_pin_d(fd),
    .inbound_ptr_clr(ic), .outbound_ptr_clr(oc), .dma_req_clr(dc),
    .gctl_out(go), .parity_ctl(pc), .ob_ae_ofs(oae), .ob_af_ofs(oaf),
    .ib_ae_ofs(iae), .ib_af_ofs(iaf), .dma_dir_read(ddr),
    .half_word_valid(hv),
    .dma_tick(tick), .ask_pol_eff(app), .grant_pol_eff(gpp),
    .ask_grant_clocks(agc), .strobe_clocks(stc), .byte_to_self(bts));

  // --------------------------------------------------
  // Clock, pulse catchers and helpers
  // --------------------------------------------------
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end

  // Reset pulses are one cycle wide, so latch them until cleared
  always @(posedge ref_clk) seen <= seen_clr ? 3'h0 : seen | {dc, oc, ic};
  always @(posedge ref_clk) if (tick) ticks++;

  // Expected status word; DMA direction is still inbound at every layout-one read
  function automatic logic [15:0] st(input logic l, input logic v);
    st[15:8] = {fl[5], fl[4], fl[3], fl[2], l, ep_r, ep_w, v};
    st[7:0] = l ? {fl[7], fl[6], fl[1], fl[0], 4'h0} : hwd;
  endfunction

  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask

  task automatic cfg(input logic [2:0] k, input logic [15:0] v);
    i_bfc_host.put(1'b1, {13'h0020, k});
    i_bfc_host.put(1'b0, v);
  endtask

  task automatic rcfg(input logic [2:0] k, input logic [15:0] e);
    i_bfc_host.put(1'b1, {13'h0020, k});
    i_bfc_host.get(1'b0, d);
    `CHK("cfg", e, d)
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Cut a hang short
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end

  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial
  begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    for (int k = 0; k < 8; k++)
      rcfg(k[2:0], k == 4 ? 16'h6420 : 16'h0000);
    i_bfc_host.get(1'b1, d);
    `CHK("status0", st(1'b0, 1'b0), d)
    cfg(3'h6, 16'hffff);
    rcfg(3'h6, 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      cfg(k[2:0], 16'hffff);
      rcfg(k[2:0], 16'h03ff);
    end
    // Every code on every pin, top bit repeating the low codes
    for (int c = 0; c < 16; c++)
    begin
      cfg(3'h4, {4'(c + 3), 4'(c + 2), 4'(c + 1), 4'(c)});
      repeat (3) @(negedge ref_clk);
      `CHK("pin_a", fl[c % 8], fa)
      `CHK("pin_b", fl[(c + 1) % 8], fb)
      `CHK("pin_c", fl[(c + 2) % 8], fc)
      `CHK("pin_d", fl[(c + 3) % 8], fd)
    end
    // Each reset operand, with layout one and a parity error standing
    cfg(3'h0, 16'h0155);
    @(negedge ref_clk);
    `CHK("ofs_out", {10'h155, 30'h3fffffff}, {oae, oaf, iae, iaf})
    i_bfc_host.put(1'b1, 16'h0701);
    pulse(wpe);
    ep_w = 1'b1;
    for (int op = 0; op < 8; op++)
    begin
      pulse(hw_wr);
      seen_clr = 1'b1;
      @(negedge ref_clk);
      seen_clr = 1'b0;
      i_bfc_host.put(1'b1, 16'(op));
      repeat (3) @(negedge ref_clk);
      ib = op == 1 || op == 3 || op == 7;
      hv_e = !ib;
      `CHK("inb_clr", ib, seen[0])
      `CHK("outb_clr", op == 2 || op == 3 || op == 7, seen[1])
      `CHK("dma_clr", op == 4 || op == 7, seen[2])
      `CHK("hw_valid", hv_e, hv)
      i_bfc_host.get(1'b1, d);
      `CHK("status1", st(1'b1, hv_e), d)
      rcfg(3'h0, op == 7 ? 16'h0000 : 16'h0155);
    end
    // Writes made while the enable is low must be lost
    clk_en = 1'b0;
    cfg(3'h0, 16'h0011);
    clk_en = 1'b1;
    rcfg(3'h0, 16'h0000);
    i_bfc_host.put(1'b1, 16'h0a00);
    ep_w = 1'b0;
    pulse(rpe);
    ep_r = 1'b1;
    i_bfc_host.get(1'b1, d);
    `CHK("par_err", st(1'b1, hv_e), d)
    cfg(3'h7, 16'h0800);
    repeat (2) @(negedge ref_clk);
    `CHK("pin_a_par", 1'b1, fa)
    `CHK("par_ctl", 16'h0800, pc)
    i_bfc_host.put(1'b1, 16'h0b00);
    i_bfc_host.put(1'b1, 16'h0700);
    ep_r = 1'b0;
    i_bfc_host.get(1'b1, d);
    `CHK("status0b", st(1'b0, hv_e), d)
    pulse(hw_wr);
    pulse(hw_mg);
    repeat (2) @(negedge ref_clk);
    `CHK("merged", 1'b0, hv)
    // Peripheral mode: delay codes, strobe width, polarities
    for (int c = 0; c < 4; c++)
    begin
      cfg(3'h5, 16'h053f | 16'(c << 6));
      repeat (3) @(negedge ref_clk);
      `CHK("gctl", 16'h053f | 16'(c << 6), 16'(go))
      `CHK("ask_grant", 3'(c + 2), agc)
      `CHK("strobe", 2'h2, stc)
      `CHK("pols", 2'h3, {app, gpp})
    end
    i_bfc_host.put(1'b1, 16'h0601);
    repeat (2) @(negedge ref_clk);
    `CHK("dma_dir", 1'b1, ddr)
    cfg(3'h5, 16'h01ff);
    repeat (3) @(negedge ref_clk);
    `CHK("proc", 7'h24, {agc, stc, app, gpp})
    i_bfc_host.put(1'b1, 16'h0600);
    repeat (2) @(negedge ref_clk);
    `CHK("dir_proc", 1'b1, ddr)
    // Internal DMA clock at full and half rate
    for (int h = 0; h < 2; h++)
    begin
      cfg(3'h5, h ? 16'h0600 : 16'h0400);
      i_bfc_host.put(1'b1, 16'h0004);
      repeat (3) @(negedge ref_clk);
      t0 = ticks;
      repeat (8)
      begin
        dclk = 1'b1;
        repeat (2) @(negedge ref_clk);
        dclk = 1'b0;
        repeat (2) @(negedge ref_clk);
      end
      `CHK("ticks", h ? 4 : 8, ticks - t0)
    end
    // Master hands bytes 0 and 1 of each four to the slave
    cfg(3'h5, 16'h0800);
    i_bfc_host.put(1'b1, 16'h0003);
    repeat (2) @(negedge ref_clk);
    for (int i = 0; i < 8; i++)
    begin
      `CHK("to_self", i[1], bts)
      pulse(nb);
      @(negedge ref_clk);
    end
    cfg(3'h5, 16'h0000);
    repeat (3) @(negedge ref_clk);
    `CHK("standalone", 1'b1, bts)
    // Mid-run hardware reset undoes what no software reset may touch
    i_bfc_host.put(1'b1, 16'h0701);
    pulse(wpe);
    pulse(hw_wr);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    `CHK("dir_rst", 1'b0, ddr)
    i_bfc_host.get(1'b1, d);
    `CHK("status_rst", st(1'b0, 1'b0), d)
    rcfg(3'h7, 16'h0000);
    print_verdict();
  end
endmodule
